// ### hdl/dbg_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef DBG_DEFINES_VH
`define DBG_DEFINES_VH

// Register byte offsets (word aligned)
`define DBG_CTRL 6'h00
`define DBG_STATUS 6'h04
`define DBG_IRQ_MASK 6'h08
`define DBG_BUS_MIN 6'h0c
`define DBG_BUS_MAX 6'h10
`define DBG_DECEL_V 6'h14
`define DBG_BRK_ON_V 6'h18
`define DBG_BRK_OFF_V 6'h1c
`define DBG_BRK_MAX_MS 6'h20
`define DBG_BRK_COOL_MS 6'h24
`define DBG_DEAD_TIME 6'h28
`define DBG_OC_REF 6'h2c
`define DBG_CUR_LIMITS 6'h30
`define DBG_SAMPLES 6'h34
`define DBG_DUTY 6'h38
`define DBG_STATE 6'h3c

// Control bit positions
`define DBG_CTRL_BRK_EN 0
`define DBG_CTRL_RUN 1
`define DBG_CTRL_CLR 2

// Fault / event bit positions in status and mask
`define DBG_EV_UV 0
`define DBG_EV_OV 1
`define DBG_EV_OC 2
`define DBG_EV_ILO 3
`define DBG_EV_IHI 4
`define DBG_EV_PSM 5
`define DBG_EV_TEMP 6
`define DBG_EV_BRKTO 7
`define DBG_NEV 8

// Reset values of settings (volts, milliseconds; dead time in clock cycles)
`define DBG_BUS_MIN_RST 16'h00fa
`define DBG_BUS_MAX_RST 16'h0186
`define DBG_DECEL_V_RST 16'h015e
`define DBG_BRK_ON_RST 16'h0168
`define DBG_BRK_OFF_RST 16'h015e
`define DBG_BRK_MAX_RST 16'hea60
`define DBG_BRK_COOL_RST 16'hd6d8
`define DBG_DEAD_RST 8'h10

// Timing: 50 MHz clock, 1 ms tick, 10 us trip limit
`define DBG_CLK_HZ 50000000
`define DBG_MS_CYC (`DBG_CLK_HZ / 1000)
`define DBG_OC_US 10
`define DBG_OC_CYC (`DBG_OC_US * (`DBG_CLK_HZ / 1000000))
// Comparator reference step, microvolts per code (137.5 mV)
`define DBG_OC_STEP_UV 137500
// Current sample step, microamps per code (6.67 mA)
`define DBG_CUR_STEP_UA 6670
`define DBG_CUR_W 10

`endif

// ### hdl/dbg_tick.v
// Millisecond tick divider producing a one-cycle enable
`timescale 1ns/10ps
`include "dbg_defines.vh"
module dbg_tick #(
  parameter MS_CYC = `DBG_MS_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Tick out
  output reg tick
);
  reg [31:0] cnt;

  // Free running divider
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else if (cnt == MS_CYC - 1) begin
      cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ### hdl/dbg_pwm_pair.v
// One complementary PWM pair with programmable dead time
`timescale 1ns/10ps
`include "dbg_defines.vh"
module dbg_pwm_pair (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire enable,
  input wire [7:0] cnt,
  input wire [7:0] duty,
  input wire [7:0] dead,
  // Gate drive outputs
  output reg gate_hi,
  output reg gate_lo
);
  reg want_hi;
  reg [7:0] dt;

  // Dead band: both off until dt expires after a change of side
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      want_hi <= 1'b0;
      dt <= 8'h0;
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else if (!enable) begin
      want_hi <= 1'b0;
      dt <= dead;
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else if ((cnt < duty) != want_hi) begin
      want_hi <= (cnt < duty);
      dt <= dead;
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else if (dt != 8'h0) begin
      dt <= dt - 8'h1;
    end else begin
      gate_hi <= want_hi;
      gate_lo <= !want_hi;
    end
  end
endmodule

// ### hdl/dbg_guard.v
// DC bus guard, dynamic brake, fault latch and three-phase PWM top
// Notes on behaviour
// - Bus below minimum setting raises under-voltage fault.
// - Bus above maximum setting raises over-voltage fault.
// - Bus at deceleration-limit voltage flags reduced deceleration.
// - Brake output only asserted while brake enable bit set.
// - Brake forced off after continuous max on-time in milliseconds.
// - After forced off, brake inhibited for max minus cool time.
// - Enabled, not inhibited brake turns on above on-voltage.
// - Brake stays on until bus drops below off-voltage.
// - Three complementary PWM pairs, one per phase, to power stage.
// - Programmable dead time between one pair output off and other on.
// - Overcurrent comparator trip, programmable reference, acts within 10 us.
// - Phase current sampled as 10-bit codes for limit checks.
// - Any bus, current, module or temperature fault stops drive.
// - Faults stay latched until software issues an explicit clear.
`timescale 1ns/10ps
`include "dbg_defines.vh"
module dbg_guard #(
  parameter MS_CYC = `DBG_MS_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Sampled measurements
  input wire [15:0] bus_volts,
  input wire [9:0] phase_current,
  input wire oc_comp_trip,
  input wire power_stage_module_fault,
  input wire over_temp,
  // Drive outputs
  output reg [2:0] pwm_hi,
  output reg [2:0] pwm_lo,
  output reg [4:0] oc_ref,
  output reg brake,
  output reg decel_limit,
  output reg drive_on,
  output reg irq
);
  ////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [2:0] ctrl;
  reg [`DBG_NEV-1:0] status;
  reg [`DBG_NEV-1:0] mask;
  reg [15:0] bus_min;
  reg [15:0] bus_max;
  reg [15:0] decel_v;
  reg [15:0] brk_on_v;
  reg [15:0] brk_off_v;
  reg [15:0] brk_max_ms;
  reg [15:0] brk_cool_ms;
  reg [7:0] dead;
  reg [9:0] cur_lo;
  reg [9:0] cur_hi;
  reg [7:0] duty [0:2];
  reg [15:0] bus_s;
  reg [9:0] cur_s;
  reg [15:0] on_ms;
  reg [15:0] cool_ms;
  reg inhibit;
  reg [7:0] pwm_cnt;
  reg [`DBG_NEV-1:0] ev;
  wire tick;
  wire [2:0] gh;
  wire [2:0] gl;
  wire access;
  wire [15:0] cool_span;

  // Single-cycle wait: first cycle waits, second cycle completes
  assign access = (avs_read || avs_write) && avs_waitrequest == 1'b0;
  assign cool_span = (brk_max_ms > brk_cool_ms) ?
                     (brk_max_ms - brk_cool_ms) : 16'h0;

  // Byte offset to word readback
  function [31:0] rd_mux;
    input [5:0] a;
    begin
      case (a)
        `DBG_CTRL: rd_mux = {29'h0, ctrl};
        `DBG_STATUS: rd_mux = {24'h0, status};
        `DBG_IRQ_MASK: rd_mux = {24'h0, mask};
        `DBG_BUS_MIN: rd_mux = {16'h0, bus_min};
        `DBG_BUS_MAX: rd_mux = {16'h0, bus_max};
        `DBG_DECEL_V: rd_mux = {16'h0, decel_v};
        `DBG_BRK_ON_V: rd_mux = {16'h0, brk_on_v};
        `DBG_BRK_OFF_V: rd_mux = {16'h0, brk_off_v};
        `DBG_BRK_MAX_MS: rd_mux = {16'h0, brk_max_ms};
        `DBG_BRK_COOL_MS: rd_mux = {16'h0, brk_cool_ms};
        `DBG_DEAD_TIME: rd_mux = {24'h0, dead};
        `DBG_OC_REF: rd_mux = {27'h0, oc_ref};
        `DBG_CUR_LIMITS: rd_mux = {6'h0, cur_hi, 6'h0, cur_lo};
        `DBG_SAMPLES: rd_mux = {6'h0, cur_s, bus_s};
        `DBG_DUTY: rd_mux = {8'h0, duty[2], duty[1], duty[0]};
        `DBG_STATE: rd_mux = {on_ms[15:0], 11'h0, inhibit, drive_on,
                              decel_limit, brake, irq};
        default: rd_mux = 32'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Tick divider
  dbg_tick #(
    .MS_CYC(MS_CYC)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: waitrequest high by default, drops for one cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux(avs_address);
      end
    end
  end

  // Settings registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 3'h0;
      mask <= {`DBG_NEV{1'b0}};
      bus_min <= `DBG_BUS_MIN_RST;
      bus_max <= `DBG_BUS_MAX_RST;
      decel_v <= `DBG_DECEL_V_RST;
      brk_on_v <= `DBG_BRK_ON_RST;
      brk_off_v <= `DBG_BRK_OFF_RST;
      brk_max_ms <= `DBG_BRK_MAX_RST;
      brk_cool_ms <= `DBG_BRK_COOL_RST;
      dead <= `DBG_DEAD_RST;
      oc_ref <= 5'h1f;
      cur_lo <= 10'h0;
      cur_hi <= 10'h3ff;
      duty[0] <= 8'h0;
      duty[1] <= 8'h0;
      duty[2] <= 8'h0;
    end else begin
      ctrl[`DBG_CTRL_CLR] <= 1'b0; // clear is a self-clearing strobe
      if (access && avs_write) begin
        case (avs_address)
          `DBG_CTRL: ctrl <= avs_writedata[2:0];
          `DBG_IRQ_MASK: mask <= avs_writedata[`DBG_NEV-1:0];
          `DBG_BUS_MIN: bus_min <= avs_writedata[15:0];
          `DBG_BUS_MAX: bus_max <= avs_writedata[15:0];
          `DBG_DECEL_V: decel_v <= avs_writedata[15:0];
          `DBG_BRK_ON_V: brk_on_v <= avs_writedata[15:0];
          `DBG_BRK_OFF_V: brk_off_v <= avs_writedata[15:0];
          `DBG_BRK_MAX_MS: brk_max_ms <= avs_writedata[15:0];
          `DBG_BRK_COOL_MS: brk_cool_ms <= avs_writedata[15:0];
          `DBG_DEAD_TIME: dead <= avs_writedata[7:0];
          `DBG_OC_REF: oc_ref <= avs_writedata[4:0];
          `DBG_CUR_LIMITS: begin
            cur_lo <= avs_writedata[9:0];
            cur_hi <= avs_writedata[25:16];
          end
          `DBG_DUTY: begin
            duty[0] <= avs_writedata[7:0];
            duty[1] <= avs_writedata[15:8];
            duty[2] <= avs_writedata[23:16];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event detection: bus, current and brake checks per tick, OC, module and temperature direct
  always @* begin
    ev = {`DBG_NEV{1'b0}};
    ev[`DBG_EV_UV] = tick && (bus_s < bus_min);
    ev[`DBG_EV_OV] = tick && (bus_s > bus_max);
    // Comparator is combinational path to the latch: one cycle, well < 10 us
    ev[`DBG_EV_OC] = oc_comp_trip;
    ev[`DBG_EV_ILO] = tick && drive_on && (cur_s < cur_lo);
    ev[`DBG_EV_IHI] = tick && (cur_s > cur_hi);
    ev[`DBG_EV_PSM] = power_stage_module_fault;
    ev[`DBG_EV_TEMP] = over_temp;
    ev[`DBG_EV_BRKTO] = tick && brake && (on_ms + 16'h1 >= brk_max_ms);
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= {`DBG_NEV{1'b0}};
    end else if (access && avs_write && avs_address == `DBG_STATUS) begin
      status <= (status & ~avs_writedata[`DBG_NEV-1:0]) | ev;
    end else begin
      status <= status | ev;
    end
  end

  // Samples latched once per tick, faults latched until manual clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_s <= 16'h0;
      cur_s <= 10'h0;
      decel_limit <= 1'b0;
      drive_on <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (tick) begin
        bus_s <= bus_volts;
        cur_s <= phase_current;
        decel_limit <= (bus_s >= decel_v);
      end
      irq <= |(status & mask);
      // Any fault except brake timeout drops the drive; only the clear strobe rearms it
      if (|(ev[`DBG_EV_TEMP:0]) || |(status[`DBG_EV_TEMP:0])) begin
        drive_on <= 1'b0;
      end else if (ctrl[`DBG_CTRL_CLR] || !ctrl[`DBG_CTRL_RUN]) begin
        drive_on <= ctrl[`DBG_CTRL_RUN] && ctrl[`DBG_CTRL_CLR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dynamic brake: hysteresis, max on-time, cooling lockout
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brake <= 1'b0;
      on_ms <= 16'h0;
      cool_ms <= 16'h0;
      inhibit <= 1'b0;
    end else if (!ctrl[`DBG_CTRL_BRK_EN]) begin
      brake <= 1'b0;
      on_ms <= 16'h0;
      cool_ms <= 16'h0;
      inhibit <= 1'b0;
    end else if (tick) begin
      if (brake) begin
        if (on_ms + 16'h1 >= brk_max_ms) begin
          brake <= 1'b0;
          on_ms <= 16'h0;
          inhibit <= (cool_span != 16'h0);
          cool_ms <= 16'h0;
        end else if (bus_s < brk_off_v) begin
          brake <= 1'b0;
          on_ms <= 16'h0;
        end else begin
          on_ms <= on_ms + 16'h1;
        end
      end else if (inhibit) begin
        // Cooling keeps the resistor from cooking on repeated surges
        if (cool_ms + 16'h1 >= cool_span) begin
          inhibit <= 1'b0;
          cool_ms <= 16'h0;
        end else begin
          cool_ms <= cool_ms + 16'h1;
        end
      end else if (bus_s > brk_on_v) begin
        brake <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM carrier and three phase pairs
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt <= 8'h0;
      pwm_hi <= 3'h0;
      pwm_lo <= 3'h0;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h1;
      pwm_hi <= gh & {3{drive_on}};
      pwm_lo <= gl & {3{drive_on}};
    end
  end

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_phase
      dbg_pwm_pair u_pair (
        .clk(clk),
        .rst_b(rst_b),
        .enable(drive_on),
        .cnt(pwm_cnt),
        .duty(duty[p]),
        .dead(dead),
        .gate_hi(gh[p]),
        .gate_lo(gl[p])
      );
    end
  endgenerate
endmodule

// ### test/dbg_guard_chk.sv
// Port-level timing checks for the bus guard
`timescale 1ns/10ps
module dbg_guard_chk (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Bus
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Fault inputs
  input wire oc_comp_trip,
  input wire power_stage_module_fault,
  // Drive outputs
  input wire [2:0] pwm_hi,
  input wire [2:0] pwm_lo,
  input wire brake,
  input wire drive_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Request and completed control write
  wire req = avs_read | avs_write;
  wire ctl_wr = avs_write & !avs_waitrequest & (avs_address == 6'h00);
  ////////////////////////////////////////////////////////////////////
  a_wait_one: assert property ($rose(req) |=> !avs_waitrequest)
    else $error("bus answer not one wait state");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_no_shoot: assert property ((pwm_hi & pwm_lo) == 3'h0)
    else $error("both gates of a pair on");
  a_psm_stop: assert property (power_stage_module_fault |-> ##[1:2] !drive_on)
    else $error("drive kept on after module fault");
  a_oc_stop: assert property (oc_comp_trip |-> ##[1:2] !drive_on)
    else $error("drive kept on after overcurrent");
  a_pwm_off: assert property (!drive_on ##1 !drive_on |->
    pwm_hi == 3'h0 && pwm_lo == 3'h0)
    else $error("gates active while drive off");
  a_drive_latch: assert property (!drive_on && !ctl_wr && !$past(ctl_wr)
    && !$past(ctl_wr, 2) |=> !drive_on)
    else $error("drive restarted without clear");
  a_brake_hold: assert property ($rose(brake) && !avs_write |=> brake)
    else $error("brake dropped right after rising");
endmodule
bind dbg_guard dbg_guard_chk dbg_guard_chk_inst (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .oc_comp_trip(oc_comp_trip),
  .power_stage_module_fault(power_stage_module_fault), .pwm_hi(pwm_hi),
  .pwm_lo(pwm_lo), .brake(brake), .drive_on(drive_on));

// ### test/dbg_stage_model.sv
// Power stage model: dead-gap watch and fault line
`timescale 1ns/10ps
module dbg_stage_model #(
  parameter DEAD = 16
) (
  // Clock and gates
  input wire clk,
  input wire [2:0] pwm_hi,
  input wire [2:0] pwm_lo,
  // Fault request and line
  input wire fault_cmd,
  output wire fault,
  output int gap_err,
  output logic [5:0] seen
);
  int idle [3] = '{0, 0, 0};
  // Fault line follows the bench request
  assign fault = fault_cmd;
  initial gap_err = 0;
  initial seen = 6'h00;
  // Gate turned on too soon after its partner: shoot-through risk
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (pwm_hi[i] | pwm_lo[i]) begin
        idle[i] <= 0;
        if (idle[i] > 0 && idle[i] < DEAD - 1) gap_err <= gap_err + 1;
      end else begin
        idle[i] <= idle[i] + 1;
      end
      seen <= seen | {pwm_lo, pwm_hi};
    end
  end
endmodule

// ### test/dbg_guard_tb.sv
// Self-checking bench for the bus guard and brake
`timescale 1ns/10ps
`include "dbg_defines.vh"
module dbg_guard_tb;
  localparam T = 10;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, oc_comp_trip;
  logic fault_cmd, power_stage_module_fault, over_temp;
  logic brake, decel_limit, drive_on, irq;
  logic [5:0] avs_address, seen;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] bus_volts;
  logic [9:0] phase_current;
  logic [2:0] pwm_hi, pwm_lo;
  logic [4:0] oc_ref;
  int bad_count = 0, checked = 0, gap_err, n;
  logic [31:0] rv [8] = '{`DBG_BUS_MIN_RST, `DBG_BUS_MAX_RST,
    `DBG_DECEL_V_RST, `DBG_BRK_ON_RST, `DBG_BRK_OFF_RST, `DBG_BRK_MAX_RST,
    `DBG_BRK_COOL_RST, `DBG_DEAD_RST};
  logic [31:0] lim [2] = '{32'h03ff0200, 32'h00ff0000};
  dbg_guard #(.MS_CYC(T)) dbg_guard_inst (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .bus_volts, .phase_current, .oc_comp_trip, .power_stage_module_fault,
    .over_temp, .pwm_hi, .pwm_lo, .oc_ref, .brake, .decel_limit, .drive_on,
    .irq);
  dbg_stage_model #(.DEAD(16)) dbg_stage_model_inst (.clk, .pwm_hi, .pwm_lo,
    .fault_cmd, .fault(power_stage_module_fault), .gap_err, .seen);
  // 50 MHz clock
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("totals: %0d checks, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= 50) begin
      bad_count++;
      print_verdict;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] m, e);
    acc(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic tk(input int t);
    repeat (t * T) @(posedge clk);
  endtask
  task automatic go(input logic [31:0] c);
    wr(6'h04, 32'hff);
    wr(6'h00, c);
    tk(2);
  endtask
  // Cycles the brake stays at one level, bounded
  task automatic cnt(input logic lvl);
    n = 0;
    while (brake === lvl && n < 500) begin
      @(posedge clk);
      n++;
    end
    // A brake stuck at one level is a failure, not a hang
    if (n >= 500) begin
      bad_count++;
      print_verdict;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    rst_b = 0;
    {avs_read, avs_write, oc_comp_trip, fault_cmd, over_temp} = 5'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    bus_volts = 16'd300;
    phase_current = 10'h100;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({27'h0, oc_ref}, 32'h1f);
    for (int i = 0; i < 8; i++) rc(6'h0c + 6'(4 * i), 32'hffff, rv[i]);
    wr(6'h30, 32'h03ff0000);
    wr(6'h38, 32'h00408040);
    wr(6'h08, 32'h0);
    go(32'h6);
    chk({31'h0, drive_on}, 32'h1);
    $display("reset test done");
    bus_volts <= 16'd200;
    tk(3);
    chk({30'h0, drive_on, irq}, 32'h0);
    rc(6'h04, 32'h1, 32'h1);
    wr(6'h08, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus_volts <= 16'd300;
    tk(3);
    chk({31'h0, drive_on}, 32'h0);
    wr(6'h04, 32'h1);
    tk(1);
    chk({31'h0, irq}, 32'h0);
    go(32'h6);
    bus_volts <= 16'd400;
    tk(3);
    rc(6'h04, 32'h3, 32'h2);
    chk({31'h0, drive_on}, 32'h0);
    bus_volts <= 16'd370;
    go(32'h6);
    tk(1);
    chk({30'h0, decel_limit, brake}, 32'h2);
    go(32'h7);
    chk({31'h0, brake}, 32'h1);
    bus_volts <= 16'd355;
    tk(3);
    chk({31'h0, brake}, 32'h1);
    bus_volts <= 16'd340;
    tk(3);
    chk({30'h0, decel_limit, brake}, 32'h0);
    bus_volts <= 16'd370;
    tk(3);
    wr(6'h00, 32'h6);
    tk(1);
    chk({31'h0, brake}, 32'h0);
    rc(6'h3c, 32'hffff0000, 32'h0);
    $display("brake test done");
    wr(6'h20, 32'd5);
    wr(6'h24, 32'd2);
    // No settling wait here: the on-time count must see the brake's start
    wr(6'h04, 32'hff);
    wr(6'h00, 32'h7);
    cnt(1'b0);
    cnt(1'b1);
    chk(32'(n >= 4 * T && n <= 5 * T), 32'h1);
    rc(6'h04, 32'h80, 32'h80);
    cnt(1'b0);
    chk(32'(n >= 3 * T && n <= 4 * T), 32'h1);
    bus_volts <= 16'd300;
    go(32'h6);
    $display("on-time test done");
    oc_comp_trip <= 1'b1;
    @(posedge clk);
    oc_comp_trip <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, drive_on}, 32'h0);
    rc(6'h04, 32'h4, 32'h4);
    wr(6'h2c, 32'h0a);
    chk({27'h0, oc_ref}, 32'h0a);
    for (int i = 0; i < 2; i++) begin
      go(32'h6);
      {over_temp, fault_cmd} <= 2'(1 << i);
      repeat (3) @(posedge clk);
      {over_temp, fault_cmd} <= 2'b00;
      chk({31'h0, drive_on}, 32'h0);
      rc(6'h04, 32'h20 << i, 32'h20 << i);
    end
    rc(6'h34, 32'h03ff0000, 32'h01000000);
    for (int i = 0; i < 2; i++) begin
      wr(6'h30, 32'h03ff0000);
      go(32'h6);
      wr(6'h30, lim[i]);
      tk(3);
      rc(6'h04, 32'h8 << i, 32'h8 << i);
    end
    chk(32'(gap_err), 32'h0);
    chk({26'h0, seen}, 32'h3f);
    $display("fault test done");
    print_verdict;
  end
endmodule
